// >>> verilog/ddr_pin_front.sv
`timescale 1ns/1ps
// What this block does
// [R01] Commands are decoded from row strobe, column strobe and write enable together with chip select.
// [R02] A write beat whose mask bit is high in that beat is not stored.
// [R03] The mask is sampled once per beat, on both strobe edges.
// [R04] With the read strobe bit of extended_mode_reg_one set, the mask pin drives a read strobe during reads.
// [R05] While that read strobe is enabled the mask function is ignored and no write beat is masked.
// [R06] The complementary read strobe is driven only with both the read strobe and differential strobes on.
// [R07] With the strobe-off bit set, both complementary strobe pins stay undriven.
// [R08] All address and control pins are captured at the rising clock crossing.
// [R09] Read data is sent one beat per clock half, on both crossings.
// [R10] A registered high clock enable keeps internal clocking running; registered low stops it.
// [R11] Any cycle with chip select registered high carries no command.
// [R12] The complementary data strobe is used only when differential strobe mode is on.
// [R13] Decoding follows the standard second-generation command table.
module ddr_pin_front (
	input  wire logic                          clk,
	input  wire logic                          rst_n,
	input  wire logic                          cs_n,
	input  wire logic                          ras_n,
	input  wire logic                          cas_n,
	input  wire logic                          we_n,
	input  wire logic                          cke,
	input  wire logic [ddr_pin_pkg::BANK_W-1:0] ba,
	input  wire logic [ddr_pin_pkg::ADDR_W-1:0] addr,
	input  wire logic [ddr_pin_pkg::DQ_W-1:0]  dq_in_rise,
	input  wire logic [ddr_pin_pkg::DQ_W-1:0]  dq_in_fall,
	input  wire logic                          write_data_mask_rise,
	input  wire logic                          write_data_mask_fall,
	input  wire logic [ddr_pin_pkg::DQ_W-1:0]  array_rd_rise,
	input  wire logic [ddr_pin_pkg::DQ_W-1:0]  array_rd_fall,
	output logic                               internal_clk_on_q,
	output logic [1:0]                         store_beat_q,
	output logic [ddr_pin_pkg::DQ_W-1:0]       store_rise_q,
	output logic [ddr_pin_pkg::DQ_W-1:0]       store_fall_q,
	output logic                               read_req_q,
	output logic [ddr_pin_pkg::DQ_W-1:0]       dq_out_rise_q,
	output logic [ddr_pin_pkg::DQ_W-1:0]       dq_out_fall_q,
	output logic                               dq_oe_q,
	output logic                               dqs_oe_q,
	output logic                               dqs_n_oe_q,
	output logic                               dedicated_read_strobe_oe_q,
	output logic                               dedicated_read_strobe_n_oe_q
);
	import ddr_pin_pkg::*;

	cmd_if bus ();

	cmd_capture u_capture (
		.clk   (clk),
		.rst_n (rst_n),
		.cs_n  (cs_n),
		.ras_n (ras_n),
		.cas_n (cas_n),
		.we_n  (we_n),
		.cke   (cke),
		.ba    (ba),
		.addr  (addr),
		.bus   (bus.dec)
	);

	logic [1:0] rd_cnt_q;
	logic [1:0] rd_cnt_d;
	logic [1:0] wr_cnt_q;
	logic [1:0] wr_cnt_d;

	wire run        = bus.clk_run;
	wire diff_on    = !bus.strobe_off;
	wire rd_strobe_on = bus.read_strobe_en;
	wire rd_go      = run && bus.cmd == CMD_READ;
	wire wr_go      = run && bus.cmd == CMD_WRITE;
	wire rd_beat    = run && rd_cnt_q != 2'h0;
	wire wr_beat    = run && wr_cnt_q != 2'h0;
	// The shared pin is a strobe, not a mask, once the read strobe is on
	wire mask_rise  = write_data_mask_rise && !rd_strobe_on; // R05
	wire mask_fall  = write_data_mask_fall && !rd_strobe_on; // R05

	// A stopped clock freezes burst progress rather than dropping it
	always_comb begin // R10
		rd_cnt_d = rd_cnt_q;
		wr_cnt_d = wr_cnt_q;
		if (run) begin
			if (rd_go) begin
				rd_cnt_d = BURST_CLKS;
				wr_cnt_d = 2'h0;
			end else if (rd_cnt_q != 2'h0) begin
				rd_cnt_d = rd_cnt_q - 2'h1;
			end
			if (wr_go) begin
				wr_cnt_d = BURST_CLKS;
				rd_cnt_d = 2'h0;
			end else if (wr_cnt_q != 2'h0 && !rd_go) begin
				wr_cnt_d = wr_cnt_q - 2'h1;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			rd_cnt_q          <= 2'h0;
			wr_cnt_q          <= 2'h0;
			internal_clk_on_q <= 1'h0;
		end else begin
			rd_cnt_q          <= rd_cnt_d;
			wr_cnt_q          <= wr_cnt_d;
			internal_clk_on_q <= run; // R10
		end
	end

	// Write path: each clock carries a rise beat and a fall beat
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			store_beat_q <= 2'h0;
			store_rise_q <= '0;
			store_fall_q <= '0;
		end else begin
			store_beat_q[0] <= wr_beat && !mask_rise; // R02 R03
			store_beat_q[1] <= wr_beat && !mask_fall; // R02 R03
			store_rise_q    <= dq_in_rise;
			store_fall_q    <= dq_in_fall;
		end
	end

	// Read path: one beat on each clock crossing
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			read_req_q    <= 1'h0;
			dq_out_rise_q <= '0;
			dq_out_fall_q <= '0;
			dq_oe_q       <= 1'h0;
		end else begin
			read_req_q    <= rd_beat;
			dq_out_rise_q <= array_rd_rise; // R09
			dq_out_fall_q <= array_rd_fall; // R09
			dq_oe_q       <= rd_beat; // R09
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			dqs_oe_q                     <= 1'h0;
			dqs_n_oe_q                   <= 1'h0;
			dedicated_read_strobe_oe_q   <= 1'h0;
			dedicated_read_strobe_n_oe_q <= 1'h0;
		end else begin
			dqs_oe_q                   <= rd_beat;
			dqs_n_oe_q                 <= rd_beat && diff_on; // R07 R12
			dedicated_read_strobe_oe_q <= rd_beat && rd_strobe_on; // R04
			dedicated_read_strobe_n_oe_q <=
				rd_beat && rd_strobe_on && diff_on; // R06 R07
		end
	end

	chk_mask_rise_drop: assert property (@(posedge clk) disable iff (!rst_n)
		wr_beat && write_data_mask_rise && !rd_strobe_on
			|=> !store_beat_q[0]) // R02
		else $error("masked rise beat was stored");
	chk_mask_fall_drop: assert property (@(posedge clk) disable iff (!rst_n)
		wr_beat && !write_data_mask_fall |=> store_beat_q[1]) // R03
		else $error("unmasked fall beat was dropped");
	chk_strobe_no_mask: assert property (@(posedge clk) disable iff (!rst_n)
		wr_beat && rd_strobe_on |=> store_beat_q == 2'h3) // R05
		else $error("write masked while read strobe enabled");
	chk_strobe_drive: assert property (@(posedge clk) disable iff (!rst_n)
		rd_beat |=> dedicated_read_strobe_oe_q == $past(rd_strobe_on)) // R04
		else $error("read strobe drive does not follow mode bit");
	chk_strobe_n_gate: assert property (@(posedge clk) disable iff (!rst_n)
		dedicated_read_strobe_n_oe_q |-> dedicated_read_strobe_oe_q
			&& dqs_n_oe_q) // R06
		else $error("complementary read strobe driven alone");
	chk_diff_off_idle: assert property (@(posedge clk) disable iff (!rst_n)
		!diff_on |=> !dqs_n_oe_q && !dedicated_read_strobe_n_oe_q) // R07 R12
		else $error("complementary strobe driven with strobes off");
	chk_stop_freeze: assert property (@(posedge clk) disable iff (!rst_n)
		!run |=> $stable(rd_cnt_q) && $stable(wr_cnt_q)
			&& !internal_clk_on_q) // R10
		else $error("burst advanced with clock enable low");
	chk_read_burst: assert property (@(posedge clk) disable iff (!rst_n)
		rd_go ##1 (run && !wr_go)[*2] |-> dq_oe_q ##1 dq_oe_q) // R09
		else $error("read burst shorter than four beats");
	chk_deselect_idle: assert property (@(posedge clk) disable iff (!rst_n)
		bus.cmd == CMD_DESELECT && rd_cnt_q == 2'h0 && wr_cnt_q == 2'h0
			|=> rd_cnt_q == 2'h0 && wr_cnt_q == 2'h0) // R11
		else $error("burst started while deselected");

	cov_masked_write: cover property (@(posedge clk) disable iff (!rst_n)
		wr_beat && mask_rise);
	cov_strobe_read: cover property (@(posedge clk) disable iff (!rst_n)
		rd_beat && rd_strobe_on && diff_on);
	cov_single_read: cover property (@(posedge clk) disable iff (!rst_n)
		rd_beat && !diff_on);
	cov_clock_stop: cover property (@(posedge clk) disable iff (!rst_n)
		rd_beat ##1 !run);
endmodule

// >>> verilog/ddr_pin_pkg.sv
package ddr_pin_pkg;
	localparam int ADDR_W = 14;
	localparam int BANK_W = 3;
	localparam int DQ_W   = 8;

	// Bank code that steers a mode-set command into the first extended reg
	localparam logic [BANK_W-1:0] EMR1_BANK = 3'h1;
	// Address bit positions inside extended_mode_reg_one
	localparam int EMR1_STROBE_OFF_BIT = 10;
	localparam int EMR1_READ_STROBE_BIT = 11;
	// Reset values of the two captured extended_mode_reg_one bits
	localparam logic STROBE_OFF_RESET  = 1'h0;
	localparam logic READ_STROBE_RESET = 1'h0;

	// Burst of four beats, two per clock
	localparam logic [1:0] BURST_CLKS = 2'h2;

	typedef enum logic [2:0] {
		CMD_DESELECT = 3'b000,
		CMD_NOP      = 3'b001,
		CMD_ACTIVATE = 3'b010,
		CMD_READ     = 3'b011,
		CMD_WRITE    = 3'b100,
		CMD_PRECHARGE = 3'b101,
		CMD_REFRESH  = 3'b110,
		CMD_MODE_SET = 3'b111
	} cmd_type;
endpackage

// >>> verilog/cmd_if.sv
`timescale 1ns/1ps
interface cmd_if;
	import ddr_pin_pkg::*;
	cmd_type                cmd;
	logic                   clk_run;
	logic [BANK_W-1:0]      bank;
	logic [ADDR_W-1:0]      addr;
	logic                   read_strobe_en;
	logic                   strobe_off;

	modport dec (
		output cmd,
		output clk_run,
		output bank,
		output addr,
		output read_strobe_en,
		output strobe_off
	);
	modport core (
		input  cmd,
		input  clk_run,
		input  bank,
		input  addr,
		input  read_strobe_en,
		input  strobe_off
	);
endinterface

// >>> verilog/cmd_capture.sv
`timescale 1ns/1ps
module cmd_capture (
	input  wire logic                           clk,
	input  wire logic                           rst_n,
	input  wire logic                           cs_n,
	input  wire logic                           ras_n,
	input  wire logic                           cas_n,
	input  wire logic                           we_n,
	input  wire logic                           cke,
	input  wire logic [ddr_pin_pkg::BANK_W-1:0] ba,
	input  wire logic [ddr_pin_pkg::ADDR_W-1:0] addr,
	cmd_if.dec                                  bus
);
	import ddr_pin_pkg::*;

	logic              cs_n_q;
	logic              ras_n_q;
	logic              cas_n_q;
	logic              we_n_q;
	logic              cke_q;
	logic [BANK_W-1:0] ba_q;
	logic [ADDR_W-1:0] addr_q;
	logic              strobe_off_q;
	logic              read_strobe_q;
	cmd_type           cmd_w;
	logic              emr1_write;

	// Every command and address pin is taken on the rising clock edge
	always_ff @(posedge clk) begin // R08
		if (!rst_n) begin
			cs_n_q  <= 1'h1;
			ras_n_q <= 1'h1;
			cas_n_q <= 1'h1;
			we_n_q  <= 1'h1;
			cke_q   <= 1'h0;
			ba_q    <= '0;
			addr_q  <= '0;
		end else begin
			cs_n_q  <= cs_n;
			ras_n_q <= ras_n;
			cas_n_q <= cas_n;
			we_n_q  <= we_n;
			cke_q   <= cke;
			ba_q    <= ba;
			addr_q  <= addr;
		end
	end

	// Select is part of the code; the strobe triple picks the command
	always_comb begin // R01
		if (cs_n_q) begin
			cmd_w = CMD_DESELECT; // R11
		end else begin
			case ({ras_n_q, cas_n_q, we_n_q}) // R13
			3'b011: cmd_w = CMD_ACTIVATE;
			3'b101: cmd_w = CMD_READ;
			3'b100: cmd_w = CMD_WRITE;
			3'b010: cmd_w = CMD_PRECHARGE;
			3'b001: cmd_w = CMD_REFRESH;
			3'b000: cmd_w = CMD_MODE_SET;
			default: cmd_w = CMD_NOP;
			endcase
		end
	end

	assign emr1_write = cke_q && cmd_w == CMD_MODE_SET && ba_q == EMR1_BANK;

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			strobe_off_q  <= STROBE_OFF_RESET;
			read_strobe_q <= READ_STROBE_RESET;
		end else if (emr1_write) begin
			strobe_off_q  <= addr_q[EMR1_STROBE_OFF_BIT];
			read_strobe_q <= addr_q[EMR1_READ_STROBE_BIT];
		end
	end

	assign bus.cmd            = cmd_w;
	assign bus.clk_run        = cke_q; // R10
	assign bus.bank           = ba_q;
	assign bus.addr           = addr_q;
	assign bus.strobe_off     = strobe_off_q;
	assign bus.read_strobe_en = read_strobe_q;

	chk_deselect_masks: assert property (@(posedge clk) disable iff (!rst_n)
		cs_n_q |-> cmd_w == CMD_DESELECT) // R11
		else $error("command decoded while deselected");
	chk_emr_capture: assert property (@(posedge clk) disable iff (!rst_n)
		emr1_write |=> read_strobe_q == $past(addr_q[EMR1_READ_STROBE_BIT])
			&& strobe_off_q == $past(addr_q[EMR1_STROBE_OFF_BIT])) // R01
		else $error("extended mode bits not captured");
endmodule

// >>> bench/ctrl_model.sv
`timescale 1ns/1ps
module ctrl_model (
	input  wire logic                           clk,
	output logic                                cs_n,
	output logic                                ras_n,
	output logic                                cas_n,
	output logic                                we_n,
	output logic                                cke,
	output logic [ddr_pin_pkg::BANK_W-1:0]      ba,
	output logic [ddr_pin_pkg::ADDR_W-1:0]      addr,
	output logic [ddr_pin_pkg::DQ_W-1:0]        dq_in_rise,
	output logic [ddr_pin_pkg::DQ_W-1:0]        dq_in_fall,
	output logic                                write_data_mask_rise,
	output logic                                write_data_mask_fall
);
	import ddr_pin_pkg::*;
	initial begin
		{cs_n, ras_n, cas_n, we_n} = 4'hF;
		cke = 1'h1;
		ba = 3'h0;
		addr = 14'h0000;
		{dq_in_rise, dq_in_fall} = 16'h0000;
		{write_data_mask_rise, write_data_mask_fall} = 2'h0;
	end
	// One command, then deselect; address lines show the inverse once freed
	task automatic issue(input logic [3:0] code, input logic [BANK_W-1:0] b,
			input logic [ADDR_W-1:0] a);
		@(posedge clk);
		{cs_n, ras_n, cas_n, we_n} <= code;
		ba <= b;
		addr <= a;
		@(posedge clk);
		{cs_n, ras_n, cas_n, we_n} <= 4'hF;
		ba <= ~b;
		addr <= ~a;
	endtask
	task automatic set_write(input logic [7:0] r, input logic [7:0] f,
			input logic [1:0] m);
		@(posedge clk);
		dq_in_rise <= r;
		dq_in_fall <= f;
		{write_data_mask_fall, write_data_mask_rise} <= m;
	endtask
	task automatic set_cke(input logic v);
		@(posedge clk);
		cke <= v;
	endtask
endmodule

// >>> bench/ddr_pin_front_tb.sv
`timescale 1ns/1ps
module ddr_pin_front_tb;
	import ddr_pin_pkg::*;
	logic clk = 1'h0;
	logic rst_n = 1'h0;
	logic cs_n, ras_n, cas_n, we_n, cke, wm_r, wm_f;
	logic [BANK_W-1:0] ba;
	logic [ADDR_W-1:0] addr;
	logic [DQ_W-1:0] dq_r, dq_f, o_r, o_f, s_r, s_f;
	logic [DQ_W-1:0] arr_r = 8'hA5;
	logic [DQ_W-1:0] arr_f = 8'h3C;
	logic clk_on, rd_req, dq_oe, dqs_oe, dqs_n_oe, rs_oe, rs_n_oe;
	logic [1:0] beats;
	int num_errors = 0;
	int n_checks = 0;
	always #20 clk = ~clk;
	ctrl_model ctrl (.clk(clk), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n),
		.we_n(we_n), .cke(cke), .ba(ba), .addr(addr), .dq_in_rise(dq_r),
		.dq_in_fall(dq_f), .write_data_mask_rise(wm_r),
		.write_data_mask_fall(wm_f));
	ddr_pin_front DUT (.clk(clk), .rst_n(rst_n), .cs_n(cs_n), .ras_n(ras_n),
		.cas_n(cas_n), .we_n(we_n), .cke(cke), .ba(ba), .addr(addr),
		.dq_in_rise(dq_r), .dq_in_fall(dq_f), .write_data_mask_rise(wm_r),
		.write_data_mask_fall(wm_f), .array_rd_rise(arr_r),
		.array_rd_fall(arr_f), .internal_clk_on_q(clk_on),
		.store_beat_q(beats), .store_rise_q(s_r), .store_fall_q(s_f),
		.read_req_q(rd_req), .dq_out_rise_q(o_r), .dq_out_fall_q(o_f),
		.dq_oe_q(dq_oe), .dqs_oe_q(dqs_oe), .dqs_n_oe_q(dqs_n_oe),
		.dedicated_read_strobe_oe_q(rs_oe),
		.dedicated_read_strobe_n_oe_q(rs_n_oe));
	task automatic check(input string what, input logic [7:0] seen,
			input logic [7:0] exp);
		n_checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("unexpected %s: expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic close_out;
		$display("checks %0d errors %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	// Burst lasts two clocks after a two-clock decode gap
	task automatic check_read(input logic en_n, input logic rs, input logic rsn);
		ctrl.issue(4'h5, 3'h0, 14'h0000);
		repeat (2) @(posedge clk);
		#1;
		for (int i = 0; i < 2; i++) begin
			check("dq_oe", dq_oe, 8'h01);
			check("rd_req", rd_req, 8'h01);
			check("dqs_oe", dqs_oe, 8'h01);
			check("rise", o_r, arr_r);
			check("fall", o_f, arr_f);
			check("dqs_n_oe", dqs_n_oe, {7'h00, en_n});
			check("rs_oe", rs_oe, {7'h00, rs});
			check("rs_n_oe", rs_n_oe, {7'h00, rsn});
			@(posedge clk);
			#1;
		end
		check("dq_oe end", dq_oe, 8'h00);
		check("rd_req end", rd_req, 8'h00);
		check("rs_oe end", rs_oe, 8'h00);
	endtask
	task automatic check_write(input logic [1:0] m, input logic [1:0] exp);
		ctrl.set_write(8'h5A, 8'hC3, m);
		ctrl.issue(4'h4, 3'h0, 14'h0000);
		repeat (2) @(posedge clk);
		#1;
		for (int i = 0; i < 2; i++) begin
			check("beats", beats, {6'h00, exp});
			if (exp[0])
				check("store_rise", s_r, 8'h5A);
			if (exp[1])
				check("store_fall", s_f, 8'hC3);
			@(posedge clk);
			#1;
		end
		check("beats end", beats, 8'h00);
	endtask
	task automatic test_masks;
		for (int m = 0; m < 4; m++)
			check_write(m[1:0], ~m[1:0]);
	endtask
	task automatic test_deselect;
		ctrl.issue(4'hD, 3'h0, 14'h0000);
		repeat (4) begin
			@(posedge clk);
			#1;
			check("deselected read", dq_oe, 8'h00);
		end
	endtask
	task automatic test_cke;
		ctrl.set_cke(1'h0);
		repeat (2) @(posedge clk);
		#1;
		check("clk off", clk_on, 8'h00);
		ctrl.set_cke(1'h1);
		repeat (2) @(posedge clk);
		#1;
		check("clk on", clk_on, 8'h01);
	endtask
	// Mode set into the first extended register
	task automatic test_strobes;
		ctrl.issue(4'h0, EMR1_BANK, 14'h0800);
		check_read(1'h1, 1'h1, 1'h1);
		check_write(2'h3, 2'h3);
		ctrl.issue(4'h0, EMR1_BANK, 14'h0C00);
		check_read(1'h0, 1'h1, 1'h0);
	endtask
	initial begin
		#(40 * 2000);
		num_errors++;
		close_out();
	end
	initial begin
		repeat (10) @(posedge clk);
		rst_n <= 1'h1;
		check_read(1'h1, 1'h0, 1'h0);
		test_masks();
		test_deselect();
		test_cke();
		test_strobes();
		close_out();
	end
endmodule
